/* rtl/mac_pcs_config_port.sv */
`timescale 1ns/100ps
// Functional notes
// R1 - Serial mode: timer words 0x0D40 and 0x03
// R2 - 1000BASE-X: timer words 0x12D0 and 0x13
// R3 - Serial mode: write 0x0003 to interface mode
// R4 - Device defaults interface mode to 1000BASE-X
// R5 - Write 0x1140 to enable auto-negotiation
// R6 - Write 0x9140, poll until reset bit clears
// R7 - Clear speed bit 3 and bit 25
// R8 - Half duplex reported: set bit 10
// R9 - Hold device reset at least three cycles
// R10 - Device derives rates from clock enables
// R11 - Data sampled on rising link clock edges
// R12 - Register clock at most 125 MHz
// R13 - Eight-bit word address, 32-bit data buses
// R14 - Device holds busy until access completes
// R15 - Separate write and read strobes from master
// R16 - Interface mode bit meanings in device
// R17 - Device clears MAC soft reset itself
// R18 - Read data valid when busy drops
// R19 - Master holds access stable while busy
module mac_pcs_config_port
  import cfg_pkg::*;
#(
  parameter longint CLK_HZ = 20_000_000
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic serial_mode,
  input wire logic half_duplex,
  output logic busy,
  output logic done,
  output logic dev_reset,
  output logic reg_wr,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_data_in,
  input wire logic reg_busy,
  input wire logic [DATA_W-1:0] reg_data_out
);

  if (CLK_HZ > REG_CLK_MAX_HZ) begin : g_clk_check // see R12
    $error("register clock above device limit");
  end

  logic [1:0] rst_pipe;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_pipe[1];

  typedef struct packed {
    seq_state_t state;
    logic [1:0] cnt;
    logic dev_reset;
    logic req;
    logic req_wr;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic pending;
    logic serial;
    logic half;
    logic busy;
    logic done;
  } seq_t;

  seq_t s;
  seq_t next_s;
  logic ack;
  logic [DATA_W-1:0] rdata;

  function automatic seq_t issue(input seq_t cur, input logic wr, input logic [7:0] addr,
                                 input logic [15:0] data);
    seq_t r;
    r = cur;
    r.req = 1'b1;
    r.req_wr = wr;
    r.req_addr = addr;
    r.req_data = {16'h0000, data};
    r.pending = 1'b1;
    issue = r;
  endfunction

  always_comb begin
    logic [DATA_W-1:0] cmd;
    cmd = rdata;
    next_s = s;
    next_s.req = 1'b0;
    case (s.state)
      S_IDLE, S_DONE: begin
        if (start) begin
          next_s.state = S_RESET;
          next_s.serial = serial_mode;
          next_s.half = half_duplex;
          next_s.cnt = 2'h0;
          next_s.dev_reset = 1'b1;
          next_s.done = 1'b0;
          next_s.busy = 1'b1;
        end
      end
      S_RESET: begin
        if (s.cnt == 2'(DEV_RESET_CYCLES - 2'h1)) begin // see R9
          next_s.dev_reset = 1'b0;
          next_s.state = S_TLOW;
        end else begin
          next_s.cnt = 2'(s.cnt + 2'h1);
        end
      end
      S_TLOW: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b1, pcs_addr(AN_TIMER_LOW),
                         s.serial ? TIMER_LOW_SERIAL : TIMER_LOW_BASEX); // see R1 see R2
        end else if (ack) begin
          next_s.pending = 1'b0;
          next_s.state = S_THIGH;
        end
      end
      S_THIGH: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b1, pcs_addr(AN_TIMER_HIGH),
                         s.serial ? TIMER_HIGH_SERIAL : TIMER_HIGH_BASEX); // see R1 see R2
        end else if (ack) begin
          next_s.pending = 1'b0;
          next_s.state = S_IFMODE;
        end
      end
      S_IFMODE: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b1, pcs_addr(IF_MODE),
                         s.serial ? IF_MODE_SERIAL : IF_MODE_BASEX); // see R3
        end else if (ack) begin
          next_s.pending = 1'b0;
          next_s.state = S_AN;
        end
      end
      S_AN: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b1, pcs_addr(PCS_CONTROL), PCS_CTRL_AN); // see R5
        end else if (ack) begin
          next_s.pending = 1'b0;
          next_s.state = S_PCSRST;
        end
      end
      S_PCSRST: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b1, pcs_addr(PCS_CONTROL), PCS_CTRL_RESET); // see R6
        end else if (ack) begin
          next_s.pending = 1'b0;
          next_s.state = S_POLL;
        end
      end
      S_POLL: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b0, pcs_addr(PCS_CONTROL), 16'h0000);
        end else if (ack) begin
          next_s.pending = 1'b0;
          if (!rdata[PCS_RESET_BIT]) begin // see R6
            next_s.state = S_CMDRD;
          end
        end
      end
      S_CMDRD: begin
        if (!s.pending) begin
          next_s = issue(s, 1'b0, CMD_CONFIG, 16'h0000);
        end else if (ack) begin
          cmd[CMD_SPEED_BIT] = 1'b0; // see R7
          cmd[CMD_ENA10_BIT] = 1'b0; // see R7
          cmd[CMD_HALF_DUPLEX_BIT] = s.half; // see R8
          next_s.req = 1'b1;
          next_s.req_wr = 1'b1;
          next_s.req_addr = CMD_CONFIG;
          next_s.req_data = cmd;
          next_s.state = S_CMDWR;
        end
      end
      S_CMDWR: begin
        if (ack) begin
          next_s.pending = 1'b0;
          next_s.state = S_DONE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end
      default: begin
        next_s = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  reg_access u_access (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .req(s.req),
    .req_wr(s.req_wr),
    .req_addr(s.req_addr),
    .req_data(s.req_data),
    .ack(ack),
    .rdata(rdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_data_in(reg_data_in),
    .reg_busy(reg_busy),
    .reg_data_out(reg_data_out)
  );

  assign busy = s.busy;
  assign done = s.done;
  assign dev_reset = s.dev_reset;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence pcs_reset_write;
    reg_wr && reg_addr == pcs_addr(PCS_CONTROL) && reg_data_in[15:0] == PCS_CTRL_RESET && !reg_busy;
  endsequence

  sequence poll_read;
    ##[1:4] reg_rd && reg_addr == pcs_addr(PCS_CONTROL);
  endsequence

  timer_serial_a: assert property (reg_wr && s.serial && reg_addr == pcs_addr(AN_TIMER_LOW) |-> // see R1
    reg_data_in == {16'h0000, TIMER_LOW_SERIAL})
    else $error("serial timer low word wrong");

  timer_basex_a: assert property (reg_wr && !s.serial && reg_addr == pcs_addr(AN_TIMER_HIGH) |-> // see R2
    reg_data_in == {16'h0000, TIMER_HIGH_BASEX})
    else $error("1000BASE-X timer high word wrong");

  if_mode_a: assert property (reg_wr && reg_addr == pcs_addr(IF_MODE) |-> // see R3
    reg_data_in[15:0] == (s.serial ? IF_MODE_SERIAL : IF_MODE_BASEX))
    else $error("interface mode value wrong");

  an_enable_a: assert property (s.state == S_AN && reg_wr |-> reg_data_in[15:0] == PCS_CTRL_AN) // see R5
    else $error("auto-negotiation enable value wrong");

  reset_poll_a: assert property (pcs_reset_write |-> poll_read) // see R6
    else $error("no poll after PCS reset");

  poll_wait_a: assert property (s.state == S_POLL && ack && rdata[PCS_RESET_BIT] |=> // see R6
    s.state == S_POLL ##1 s.req && !s.req_wr)
    else $error("left poll while reset bit set");

  cmd_bits_a: assert property (reg_wr && reg_addr == CMD_CONFIG |-> // see R7
    !reg_data_in[CMD_SPEED_BIT] && !reg_data_in[CMD_ENA10_BIT] && reg_data_in[CMD_HALF_DUPLEX_BIT] == s.half) // see R8
    else $error("command configuration bits wrong");

  dev_reset_hold_a: assert property ($rose(dev_reset) |-> dev_reset [*3]) // see R9
    else $error("device reset shorter than three cycles");

endmodule

/* rtl/cfg_pkg.sv */
package cfg_pkg;

  // Device register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register clock ceiling of the device
  localparam longint REG_CLK_MAX_HZ = 125_000_000;

  // Word addresses in the device register map; PCS registers as offsets from PCS_BASE
  localparam logic [7:0] PCS_BASE = 8'h80;
  localparam logic [7:0] CMD_CONFIG = 8'h02;
  localparam logic [7:0] PCS_CONTROL = 8'h00;
  localparam logic [7:0] AN_TIMER_LOW = 8'h12;
  localparam logic [7:0] AN_TIMER_HIGH = 8'h13;
  localparam logic [7:0] IF_MODE = 8'h14;

  // Auto-negotiation timer words: 1.6 ms for serial mode, 10 ms for 1000BASE-X
  localparam logic [15:0] TIMER_LOW_SERIAL = 16'h0D40;
  localparam logic [15:0] TIMER_HIGH_SERIAL = 16'h0003;
  localparam logic [15:0] TIMER_LOW_BASEX = 16'h12D0;
  localparam logic [15:0] TIMER_HIGH_BASEX = 16'h0013;

  // Interface mode values
  localparam logic [15:0] IF_MODE_SERIAL = 16'h0003;
  localparam logic [15:0] IF_MODE_BASEX = 16'h0000;

  // PCS control values
  localparam logic [15:0] PCS_CTRL_AN = 16'h1140;
  localparam logic [15:0] PCS_CTRL_RESET = 16'h9140;
  localparam int PCS_RESET_BIT = 15;

  // Command configuration bit positions
  localparam int CMD_SPEED_BIT = 3;
  localparam int CMD_HALF_DUPLEX_BIT = 10;
  localparam int CMD_ENA10_BIT = 25;

  // Device reset pulse length in cycles
  localparam logic [1:0] DEV_RESET_CYCLES = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RESET = 4'h1,
    S_TLOW = 4'h3,
    S_THIGH = 4'h2,
    S_IFMODE = 4'h6,
    S_AN = 4'h7,
    S_PCSRST = 4'h5,
    S_POLL = 4'h4,
    S_CMDRD = 4'hC,
    S_CMDWR = 4'hD,
    S_DONE = 4'hF
  } seq_state_t;

  function automatic logic [7:0] pcs_addr(input logic [7:0] off);
    pcs_addr = 8'(PCS_BASE + off);
  endfunction

endpackage

/* rtl/reg_access.sv */
`timescale 1ns/100ps
module reg_access
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_sync_b,
  input wire logic req,
  input wire logic req_wr,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  output logic ack,
  output logic [DATA_W-1:0] rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_data_in,
  input wire logic reg_busy,
  input wire logic [DATA_W-1:0] reg_data_out
);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;
  } acc_t;

  acc_t s;
  acc_t next_s;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    if (!s.wr && !s.rd) begin
      if (req) begin
        // Only one strobe per access
        next_s.wr = req_wr; // see R15
        next_s.rd = !req_wr; // see R15
        next_s.addr = req_addr;
        next_s.wdata = req_data;
      end
    end else if (!reg_busy) begin
      // Access ends in the first cycle without busy
      next_s.wr = 1'b0;
      next_s.rd = 1'b0;
      next_s.ack = 1'b1;
      if (s.rd) begin
        next_s.rdata = reg_data_out; // see R18
      end
    end
    // Strobes, address and data held while busy, see R19
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_wr = s.wr;
  assign reg_rd = s.rd;
  assign reg_addr = s.addr;
  assign reg_data_in = s.wdata;
  assign ack = s.ack;
  assign rdata = s.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  strobe_hold_a: assert property ((reg_wr || reg_rd) && reg_busy |=> // see R19
    (reg_wr || reg_rd) && $stable(reg_addr) && $stable(reg_data_in) && $stable(reg_wr))
    else $error("strobe or address changed while busy");

  one_strobe_a: assert property (!(reg_wr && reg_rd)) // see R15
    else $error("read and write strobes together");

  read_data_a: assert property (reg_rd && !reg_busy |=> ack && rdata == $past(reg_data_out)) // see R18
    else $error("read data not captured at completion");

endmodule

/* tb/dev_model.sv */
`timescale 1ns/100ps
module dev_model
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic dev_reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_data_in,
  input wire logic [3:0] waits,
  input wire logic [DATA_W-1:0] cmd_init,
  output logic reg_busy,
  output logic [DATA_W-1:0] reg_data_out
);
  localparam int MAC_SOFT_RESET_BIT = 13;
  logic [3:0] cnt;
  logic [15:0] ctrl;
  logic [15:0] tlo;
  logic [15:0] thi;
  logic [15:0] ifm;
  logic [31:0] cmd;
  logic [31:0] val;
  logic [1:0] rc;
  logic fin;
  // Busy for the programmed number of cycles of every access
  assign reg_busy = (reg_wr | reg_rd) && cnt < waits;
  assign fin = (reg_wr | reg_rd) && !reg_busy;
  always_comb begin
    case (reg_addr)
      8'h80: val = {16'h0000, ctrl};
      8'h92: val = {16'h0000, tlo};
      8'h93: val = {16'h0000, thi};
      8'h94: val = {16'h0000, ifm};
      8'h02: val = cmd;
      default: val = 32'h00000000;
    endcase
  end
  // Read data only in the completing cycle, inverted otherwise
  assign reg_data_out = (reg_rd && !reg_busy) ? val : ~val;
  always_ff @(posedge clk) begin
    if (dev_reset) begin
      cnt <= 4'h0;
      ctrl <= 16'h0140;
      tlo <= 16'h0000;
      thi <= 16'h0000;
      ifm <= 16'h0000;
      cmd <= cmd_init;
      rc <= 2'h0;
    end else begin
      cnt <= (fin || !(reg_wr | reg_rd)) ? 4'h0 : cnt + 4'h1;
      // MAC soft reset bit clears itself one cycle later; a write in the same cycle wins
      if (cmd[MAC_SOFT_RESET_BIT]) cmd[MAC_SOFT_RESET_BIT] <= 1'b0;
      if (reg_wr && !reg_busy) begin
        case (reg_addr)
          8'h80: begin
            ctrl <= ifm[0] ? reg_data_in[15:0] : (reg_data_in[15:0] & ~16'h2140) | (ctrl & 16'h2140);
            rc <= 2'h0;
          end
          8'h92: tlo <= reg_data_in[15:0];
          8'h93: thi <= reg_data_in[15:0];
          8'h94: ifm <= reg_data_in[15:0];
          8'h02: cmd <= reg_data_in;
          default: ;
        endcase
      end
      // Reset bit clears after the second poll
      if (reg_rd && !reg_busy && reg_addr == 8'h80 && ctrl[15]) begin
        rc <= rc + 2'h1;
        if (rc == 2'h1) ctrl[15] <= 1'b0;
      end
    end
  end
endmodule

/* tb/mac_pcs_config_port_test.sv */
`timescale 1ns/100ps
module mac_pcs_config_port_test
  import cfg_pkg::*;
;
  typedef struct packed {
    logic sm;
    logic hd;
    logic [3:0] w;
    logic twice;
    logic [15:0] tlo;
    logic [15:0] thi;
    logic [15:0] ifm;
  } row_t;
  logic clk = 0;
  logic rst_b = 0;
  logic start = 0;
  logic serial_mode = 0;
  logic half_duplex = 0;
  logic [3:0] waits = 4'h0;
  logic [31:0] cmd_init = 32'h0200240A;
  logic busy, done, dev_reset, reg_wr, reg_rd, reg_busy;
  logic [7:0] reg_addr;
  logic [31:0] reg_data_in, reg_data_out;
  logic [41:0] prev;
  logic pb = 0;
  int n_mismatch = 0;
  int comparisons = 0;
  int npoll, nrst, nbad;
  logic [7:0] la[$];
  logic [31:0] ld[$];
  logic [7:0] ea [6] = '{8'h92, 8'h93, 8'h94, 8'h80, 8'h80, 8'h02};
  row_t rows [3] = '{'{1'b1, 1'b0, 4'h0, 1'b0, 16'h0D40, 16'h0003, 16'h0003},
                     '{1'b0, 1'b1, 4'h2, 1'b0, 16'h12D0, 16'h0013, 16'h0000},
                     '{1'b0, 1'b0, 4'h1, 1'b0, 16'h12D0, 16'h0013, 16'h0000}};
  row_t odd = '{1'b1, 1'b1, 4'h3, 1'b1, 16'h0D40, 16'h0003, 16'h0003};
  mac_pcs_config_port mac_pcs_config_port_inst (.clk(clk), .rst_b(rst_b), .start(start),
    .serial_mode(serial_mode), .half_duplex(half_duplex), .busy(busy), .done(done), .dev_reset(dev_reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_data_in(reg_data_in), .reg_busy(reg_busy),
    .reg_data_out(reg_data_out));
  dev_model dev_model_inst (.clk(clk), .dev_reset(dev_reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_data_in(reg_data_in), .waits(waits), .cmd_init(cmd_init), .reg_busy(reg_busy),
    .reg_data_out(reg_data_out));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    if (reg_wr === 1'b1 && reg_busy === 1'b0) begin
      la.push_back(reg_addr);
      ld.push_back(reg_data_in);
    end
    if (reg_rd === 1'b1 && reg_busy === 1'b0 && reg_addr === 8'h80) npoll++;
    if (dev_reset === 1'b1) nrst++;
    if (pb && {reg_wr, reg_rd, reg_addr, reg_data_in} !== prev) nbad++;
    prev = {reg_wr, reg_rd, reg_addr, reg_data_in};
    pb = (reg_busy === 1'b1);
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic run(input row_t r);
    int i;
    logic [31:0] ed [6];
    la.delete();
    ld.delete();
    npoll = 0;
    nrst = 0;
    nbad = 0;
    @(negedge clk);
    serial_mode = r.sm;
    half_duplex = r.hd;
    waits = r.w;
    start = 1;
    @(negedge clk);
    start = 0;
    check("busy and device reset", {busy, dev_reset}, 2'b11);
    if (r.twice) begin
      repeat (8) @(negedge clk);
      start = 1;
      @(negedge clk);
      start = 0;
    end
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
    ed = '{{16'h0000, r.tlo}, {16'h0000, r.thi}, {16'h0000, r.ifm}, 32'h00001140, 32'h00009140,
           (cmd_init & ~32'h02002408) | (32'(r.hd) << 10)};
    check("done and not busy", {done, busy}, 2'b10);
    check("write count", la.size(), 6);
    for (i = 0; i < 6 && i < la.size(); i++) begin
      check("write address", la[i], ea[i]);
      check("write data", ld[i], ed[i]);
    end
    check("poll reads", npoll, 3);
    check("device reset cycles", nrst, 3);
    check("held while busy", nbad, 0);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    check("reset outputs", {busy, done, dev_reset, reg_wr, reg_rd}, 0);
    $display("test reset finished");
    rst_b = 1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      run(rows[i]);
      $display("test row %0d finished", i);
    end
    start = 1;
    @(negedge clk);
    start = 0;
    repeat (12) @(negedge clk);
    rst_b = 0;
    #1;
    check("mid-run reset", {busy, done, dev_reset, reg_wr, reg_rd}, 0);
    repeat (6) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    $display("test mid-run reset finished");
    run(odd);
    $display("test ignored second start finished");
    results();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    results();
  end
endmodule
